/* File: inc/dsos_pkg.sv */
package dsos_pkg;

    // widths of the selection and measurement values
    localparam int CODE_W = 7;
    localparam int FREQ_W = 16;   // frequency in 0.01 Hz steps
    localparam int AIN_W  = 14;   // analog level in 0.1 steps, 0.0 .. 1023.0
    localparam int PCT_W  = 16;   // currents and overload in 0.1 % steps
    localparam int NUM_DO = 3;

    // clock and timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int FREQ_SCALE    = 100;
    localparam logic [31:0] PHASE_LIMIT = 32'(CLK_HZ * FREQ_SCALE);
    localparam int RESET_HOLD_NS = 10_000;
    localparam int HOLD_CYC      = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W        = $clog2(HOLD_CYC + 1);

    // overload warning threshold, 50.0 %
    localparam logic [PCT_W-1:0] OL_WARN_LEVEL = 16'h01F4;
    // i(%) > 150 % of ain/1023.0, scaled to integers on both sides
    localparam logic [31:0] PCT_MUL_CUR = 32'h00004FEC;  // 20460
    localparam logic [31:0] PCT_MUL_AIN = 32'h00000BB8;  // 3000

    // function codes
    localparam logic [CODE_W-1:0] FN_OFF       = 7'h00;
    localparam logic [CODE_W-1:0] FN_NOT_RUN   = 7'h01;
    localparam logic [CODE_W-1:0] FN_ALARM     = 7'h04;
    localparam logic [CODE_W-1:0] FN_NO_ALARM  = 7'h05;
    localparam logic [CODE_W-1:0] FN_BRAKING   = 7'h06;
    localparam logic [CODE_W-1:0] FN_RUNNING   = 7'h07;
    localparam logic [CODE_W-1:0] FN_SPA       = 7'h0A;
    localparam logic [CODE_W-1:0] FN_SPEED_NOT_ARRIVE      = 7'h0B;
    localparam logic [CODE_W-1:0] FN_DIR       = 7'h0C;
    localparam logic [CODE_W-1:0] FN_IRMS0     = 7'h0D;
    localparam logic [CODE_W-1:0] FN_TMR_A     = 7'h0E;
    localparam logic [CODE_W-1:0] FN_ZERO      = 7'h0F;
    localparam logic [CODE_W-1:0] FN_NONZERO   = 7'h10;
    localparam logic [CODE_W-1:0] FN_STALL     = 7'h11;
    localparam logic [CODE_W-1:0] FN_TMR_B     = 7'h14;
    localparam logic [CODE_W-1:0] FN_STEP1     = 7'h15;
    localparam logic [CODE_W-1:0] FN_FF1       = 7'h20;
    localparam logic [CODE_W-1:0] FN_FF1_N     = 7'h21;
    localparam logic [CODE_W-1:0] FN_FF2       = 7'h22;
    localparam logic [CODE_W-1:0] FN_FF2_N     = 7'h23;
    localparam logic [CODE_W-1:0] FN_ON        = 7'h26;
    localparam logic [CODE_W-1:0] FN_TMR_A_N   = 7'h28;
    localparam logic [CODE_W-1:0] FN_TMR_B_N   = 7'h29;
    localparam logic [CODE_W-1:0] FN_TMR_C     = 7'h2A;
    localparam logic [CODE_W-1:0] FN_TMR_C_N   = 7'h2B;
    localparam logic [CODE_W-1:0] FN_CLK_X32   = 7'h2C;
    localparam logic [CODE_W-1:0] FN_CLK_X1    = 7'h31;
    localparam logic [CODE_W-1:0] FN_IDC0      = 7'h32;
    localparam logic [CODE_W-1:0] FN_IDC_AIN1  = 7'h33;
    localparam logic [CODE_W-1:0] FN_IRMS_AIN1 = 7'h36;
    localparam logic [CODE_W-1:0] FN_PWR_LIM   = 7'h39;
    localparam logic [CODE_W-1:0] FN_RUN_CMP1  = 7'h46;
    localparam logic [CODE_W-1:0] FN_OL_WARN   = 7'h4E;
    localparam logic [CODE_W-1:0] FN_OL_WARN_N = 7'h4F;
    localparam logic [CODE_W-1:0] FN_CMP1      = 7'h50;
    localparam logic [CODE_W-1:0] FN_ACCEL     = 7'h56;
    localparam logic [CODE_W-1:0] FN_DECEL     = 7'h57;
    localparam logic [CODE_W-1:0] FN_DISCHARGE = 7'h58;
    localparam logic [CODE_W-1:0] FN_FWD       = 7'h5A;
    localparam logic [CODE_W-1:0] FN_REV       = 7'h5B;
    localparam logic [CODE_W-1:0] FN_TMR_C_GATE = 7'h5C;
    localparam logic [CODE_W-1:0] FN_TMR_C_N2  = 7'h5D;

    typedef logic [CODE_W-1:0] dsos_code_t;

    // live drive status sampled by the selector
    typedef struct packed {
        logic                     running;
        logic                     dc_braking;
        logic                     alarm;
        logic                     stalling;
        logic                     power_limit;
        logic                     accelerating;
        logic                     decelerating;
        logic                     discharging;
        logic                     timer_a_out;
        logic                     timer_b_out;
        logic                     timer_c_out;
        logic                     timer_c_enable_input;
        logic                     ff1_q;
        logic                     ff2_q;
        logic [3:0]               auto_step;     // 0 = idle, 1..10 = step
        logic signed [FREQ_W:0]   output_frequency_value;
        logic [FREQ_W-1:0]        set_frequency;
        logic [FREQ_W-1:0]        speed_tolerance_setting;
        logic [PCT_W-1:0]         irms_value;
        logic [PCT_W-1:0]         idc_value;
        logic [PCT_W-1:0]         irms_pct;
        logic [PCT_W-1:0]         idc_pct;
        logic [PCT_W-1:0]         current_threshold_setting;
        logic [PCT_W-1:0]         overload_level;
        logic [3*AIN_W-1:0]       analog_input;       // ain3, ain2, ain1
        logic [3*AIN_W-1:0]       ain_compare_level;  // level3, level2, level1
    } dsos_status_s;

endpackage

/* File: src/dsos_clkgen.sv */
`timescale 1ns/1ps
module dsos_clkgen
    import dsos_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              enable,
    input  wire logic [FREQ_W-1:0] freq_mag,
    input  wire logic [2:0]        mult_shift,
    output logic                   freq_multiple_clock
);

    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [31:0] step_w;
    logic [31:0] sum_w;
    logic        wrap_w;

    ////////////////////////////////////////////////////////////////
    // phase accumulator
    // two toggles per period, so the step is twice freq times the multiple
    assign step_w = 32'({freq_mag, 1'b0}) << mult_shift;
    assign sum_w  = acc_q + step_w;
    assign wrap_w = (sum_w >= PHASE_LIMIT);
    assign acc_d  = wrap_w ? sum_w - PHASE_LIMIT : sum_w;

    // parked low while disabled, so a latched clock starts on a clean phase
    always_ff @(posedge clk_sys) begin
        if (rst || !enable) begin
            acc_q               <= '0;
            freq_multiple_clock <= 1'b0;
        end else begin
            acc_q <= acc_d;
            if (wrap_w) begin
                freq_multiple_clock <= ~freq_multiple_clock;
            end
        end
    end

    a_clk_phase_range : assert property (@(posedge clk_sys) disable iff (rst)
        acc_q < PHASE_LIMIT) else $error("phase accumulator out of range");

endmodule

/* File: src/dsos_sel.sv */
`timescale 1ns/1ps
module dsos_sel
    import dsos_pkg::*;
#(
    parameter bit CLK_CAPABLE = 1'b0
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          hold,
    input  wire dsos_code_t    code,
    input  wire logic [127:0]  cond,
    input  wire logic          clk_mode,
    input  wire logic          clk_val,
    output logic               q
);

    logic pick_w;
    logic q_d;

    ////////////////////////////////////////////////////////////////
    // only the first output may carry the generated clock
    assign pick_w = (CLK_CAPABLE && clk_mode) ? clk_val : cond[code];
    // forced off through the hold interval
    assign q_d    = hold ? 1'b0 : pick_w;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= 1'b0;
        end else begin
            q <= q_d;
        end
    end

endmodule

/* File: src/dsos_top.sv */
`timescale 1ns/1ps
// Contract
// - speed-arrive on when |freq - set| within tolerance; off stopped or braking.
// - code 11 is the complement of speed-arrive.
// - code 12 on when signed output frequency is zero or positive.
// - code 13 rms current over threshold; 54-56 rms percent over 150% analog.
// - code 15 on when output frequency below tolerance; 16 complement.
// - code 17 on while running and stalling on current limit.
// - codes 21-30 on while auto run executes steps 1-10.
// - codes 32-35 drive flip-flop 1 and 2 true and inverted.
// - code 38 holds output permanently on.
// - codes 40, 41, 43, 93 drive complements of timers A, B, C.
// - codes 44-49 give square clock at output frequency times 32 down to 1.
// - frequency-multiple clock served only on the first output.
// - entering or leaving clock function on output one takes effect at reset.
// - code 50 bus current over threshold; 51-53 over 150% analog input.
// - code 57 on while in power-limit condition.
// - codes 80-85 analog above/below level; 70-75 also require running.
// - code 78 overload level above 50%; 79 complement.
// - codes 86, 87, 88 accelerating, decelerating, discharging.
// - code 90 running forward, code 91 running reverse.
// - code 92 follows timer C only while its enable input is on.
// - each output has its own independent function code.
// - code 0 holds output permanently off.
// - all outputs forced off for a short interval at reset.
module dsos_top
    import dsos_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire dsos_status_s      sts,
    input  wire dsos_code_t        fn_code_one,
    input  wire dsos_code_t        fn_code_two,
    input  wire dsos_code_t        fn_code_three,
    output logic [NUM_DO-1:0]      status_output_n
);

    if (FREQ_W > 24 || NUM_DO != 3) begin : g_chk
        $error("dsos_top: unsupported width or output count");
    end

    dsos_code_t          code_w [NUM_DO];
    logic [127:0]        cond;
    logic [HOLD_W-1:0]   hold_cnt_q;
    logic                hold_w;
    logic                clk_mode_q;
    logic [2:0]          clk_shift_q;
    logic                gen_clk_w;
    logic                freq_neg_w;
    logic [FREQ_W-1:0]   freq_mag_w;
    logic [FREQ_W-1:0]   speed_diff_w;
    logic                speed_arrive;
    logic                zero_speed;
    logic                dir_fwd_w;
    logic                ol_warn_w;
    logic [2:0]          ain_hi_w;
    logic [2:0]          ain_lo_w;
    logic [2:0]          irms_ain_w;
    logic [2:0]          idc_ain_w;
    logic                code_one_clk_w;

    assign code_w[0] = fn_code_one;
    assign code_w[1] = fn_code_two;
    assign code_w[2] = fn_code_three;

    ////////////////////////////////////////////////////////////////
    // speed and direction measures
    assign freq_neg_w   = sts.output_frequency_value[FREQ_W];
    assign freq_mag_w   = freq_neg_w ? FREQ_W'(-sts.output_frequency_value)
                                     : sts.output_frequency_value[FREQ_W-1:0];
    assign speed_diff_w = (freq_mag_w >= sts.set_frequency)
                        ? freq_mag_w - sts.set_frequency
                        : sts.set_frequency - freq_mag_w;
    // arrival gated by running and not braking
    assign speed_arrive = sts.running && !sts.dc_braking
                        && (speed_diff_w <= sts.speed_tolerance_setting);
    // strictly below tolerance counts as zero
    assign zero_speed   = (freq_mag_w < sts.speed_tolerance_setting);
    assign dir_fwd_w    = !freq_neg_w;
    assign ol_warn_w    = (sts.overload_level > OL_WARN_LEVEL);

    ////////////////////////////////////////////////////////////////
    // analog comparisons, one per analog channel
    for (genvar k = 0; k < 3; k++) begin : g_ain
        logic [AIN_W-1:0] ain_w;
        logic [AIN_W-1:0] lvl_w;
        assign ain_w = sts.analog_input[k*AIN_W +: AIN_W];
        assign lvl_w = sts.ain_compare_level[k*AIN_W +: AIN_W];
        // above and below, equal gives neither
        assign ain_hi_w[k] = (ain_w > lvl_w);
        assign ain_lo_w[k] = (ain_w < lvl_w);
        // rms percent against 150 % of the analog level
        assign irms_ain_w[k] = (32'(sts.irms_pct) * PCT_MUL_CUR) > (32'(ain_w) * PCT_MUL_AIN);
        // bus current percent against 150 % of the analog level
        assign idc_ain_w[k]  = (32'(sts.idc_pct) * PCT_MUL_CUR) > (32'(ain_w) * PCT_MUL_AIN);
    end

    ////////////////////////////////////////////////////////////////
    // condition table indexed by function code; unlisted codes stay off
    always_comb begin
        cond = '0;
        cond[FN_OFF]       = 1'b0;
        cond[FN_NOT_RUN]   = !sts.running && !sts.dc_braking;
        cond[FN_ALARM]     = sts.alarm;
        cond[FN_NO_ALARM]  = !sts.alarm;
        cond[FN_BRAKING]   = sts.dc_braking;
        cond[FN_RUNNING]   = sts.running;
        cond[FN_SPA]       = speed_arrive;
        cond[FN_SPEED_NOT_ARRIVE]      = !speed_arrive;
        cond[FN_DIR]       = dir_fwd_w;
        cond[FN_IRMS0]     = sts.irms_value > sts.current_threshold_setting;
        cond[FN_TMR_A]     = sts.timer_a_out;
        cond[FN_ZERO]      = zero_speed;
        cond[FN_NONZERO]   = !zero_speed;
        cond[FN_STALL]     = sts.running && sts.stalling;
        cond[FN_TMR_B]     = sts.timer_b_out;
        // one code per auto run step
        for (int s = 0; s < 10; s++) begin
            cond[FN_STEP1 + s] = (sts.auto_step == 4'(s + 1));
        end
        cond[FN_FF1]       = sts.ff1_q;
        cond[FN_FF1_N]     = !sts.ff1_q;
        cond[FN_FF2]       = sts.ff2_q;
        cond[FN_FF2_N]     = !sts.ff2_q;
        cond[FN_ON]        = 1'b1;
        cond[FN_TMR_A_N]   = !sts.timer_a_out;
        cond[FN_TMR_B_N]   = !sts.timer_b_out;
        cond[FN_TMR_C]     = sts.timer_c_out;
        cond[FN_TMR_C_N]   = !sts.timer_c_out;
        cond[FN_TMR_C_N2]  = !sts.timer_c_out;
        cond[FN_IDC0]      = sts.idc_value > sts.current_threshold_setting;
        for (int k = 0; k < 3; k++) begin
            cond[FN_IDC_AIN1 + k]       = idc_ain_w[k];
            cond[FN_IRMS_AIN1 + k]      = irms_ain_w[k];
            cond[FN_RUN_CMP1 + 2*k]     = sts.running && ain_hi_w[k];
            cond[FN_RUN_CMP1 + 2*k + 1] = sts.running && ain_lo_w[k];
            cond[FN_CMP1 + 2*k]         = ain_hi_w[k];
            cond[FN_CMP1 + 2*k + 1]     = ain_lo_w[k];
        end
        cond[FN_PWR_LIM]   = sts.power_limit;
        cond[FN_OL_WARN]   = ol_warn_w;
        cond[FN_OL_WARN_N] = !ol_warn_w;
        cond[FN_ACCEL]     = sts.accelerating;
        cond[FN_DECEL]     = sts.decelerating;
        cond[FN_DISCHARGE] = sts.discharging;
        cond[FN_FWD]       = sts.running && dir_fwd_w;
        cond[FN_REV]       = sts.running && !dir_fwd_w;
        // timer C gated by its enable input
        cond[FN_TMR_C_GATE] = sts.timer_c_enable_input && sts.timer_c_out;
    end

    ////////////////////////////////////////////////////////////////
    // reset hold; the counter reloads in reset and runs down after release
    assign hold_w         = (hold_cnt_q != '0);
    assign code_one_clk_w = (fn_code_one >= FN_CLK_X32) && (fn_code_one <= FN_CLK_X1);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_cnt_q <= HOLD_W'(HOLD_CYC);
        end else if (hold_w) begin
            hold_cnt_q <= hold_cnt_q - 1'b1;
        end
    end

    // clock mode and multiple sampled only while reset is held
    // keeps the pin from jumping into or out of clock mode on a live edit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_mode_q  <= code_one_clk_w;
            clk_shift_q <= code_one_clk_w ? 3'(FN_CLK_X1 - fn_code_one) : 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // frequency-multiple clock generator, first output only
    dsos_clkgen u_clkgen (
        .clk_sys             (clk_sys),
        .rst                 (rst),
        .enable              (clk_mode_q && !hold_w),
        .freq_mag            (freq_mag_w),
        .mult_shift          (clk_shift_q),
        .freq_multiple_clock (gen_clk_w)
    );

    // output stages
    for (genvar i = 0; i < NUM_DO; i++) begin : g_do
        dsos_sel #(
            .CLK_CAPABLE (i == 0)
        ) u_sel (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .hold     (hold_w),
            .code     (code_w[i]),
            .cond     (cond),
            .clk_mode (clk_mode_q),
            .clk_val  (gen_clk_w),
            .q        (status_output_n[i])
        );
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_stopped_spa;
        fn_code_three == FN_SPA && !sts.running && !hold_w;
    endsequence

    a_hold_forces_off : assert property (
        hold_w |=> status_output_n == '0) else $error("output on during reset hold");
    a_null_code_off : assert property (
        fn_code_two == FN_OFF |=> !status_output_n[1]) else $error("null code drove on");
    a_always_on_code : assert property (
        fn_code_two == FN_ON && !hold_w |=> status_output_n[1]) else $error("always-on low");
    a_spa_when_stopped : assert property (
        s_stopped_spa |=> !status_output_n[2]) else $error("speed arrive while stopped");
    a_spa_speed_not_arrive_pair : assert property (
        fn_code_two == FN_SPA && fn_code_three == FN_SPEED_NOT_ARRIVE && !hold_w
        |=> status_output_n[1] != status_output_n[2]) else $error("arrive pair not complementary");
    a_dir_follows_sign : assert property (
        fn_code_three == FN_DIR && !hold_w
        |=> status_output_n[2] == !$past(freq_neg_w)) else $error("direction mismatch");
    a_clk_not_on_three : assert property (
        fn_code_three >= FN_CLK_X32 && fn_code_three <= FN_CLK_X1
        |=> !status_output_n[2]) else $error("clock function on output three");
    a_clk_mode_frozen : assert property (
        ##1 $stable(clk_mode_q)) else $error("clock mode changed outside reset");
    a_ol_warn_level : assert property (
        fn_code_two == FN_OL_WARN && !hold_w
        |=> status_output_n[1] == ($past(sts.overload_level) > OL_WARN_LEVEL))
        else $error("overload warning mismatch");
    a_tmr_c_gated : assert property (
        fn_code_three == FN_TMR_C_GATE && !sts.timer_c_enable_input
        |=> !status_output_n[2]) else $error("timer C passed while disabled");

    // clock path, hold reload and per-code spot checks
    sequence s_clk_live;
        clk_mode_q && !hold_w;
    endsequence

    a_clk_on_one : assert property (
        s_clk_live |=> status_output_n[0] == $past(gen_clk_w)) else $error("clock lost on one");
    a_hold_reload : assert property (
        $fell(rst) |-> hold_cnt_q == HOLD_W'(HOLD_CYC)) else $error("hold not reloaded");
    a_reserved_off : assert property (
        fn_code_two inside {7'h02, 7'h13, 7'h1F, 7'h25, 7'h3A, 7'h4D, 7'h59, 7'h7F}
        |=> !status_output_n[1]) else $error("reserved code drove on");
    a_step_one : assert property (
        fn_code_two == FN_STEP1 && !hold_w
        |=> status_output_n[1] == ($past(sts.auto_step) == 4'h1)) else $error("step one wrong");
    a_stall_stopped : assert property (
        fn_code_three == FN_STALL && !sts.running |=> !status_output_n[2])
        else $error("stall while stopped");
    a_fwd_stopped : assert property (
        fn_code_two == FN_FWD && !sts.running |=> !status_output_n[1])
        else $error("forward while stopped");
    a_run_cmp_stopped : assert property (
        fn_code_three == FN_RUN_CMP1 && !sts.running |=> !status_output_n[2])
        else $error("run compare while stopped");
    a_tmr_c_comp : assert property (
        fn_code_two == FN_TMR_C_N2 && !hold_w
        |=> status_output_n[1] != $past(sts.timer_c_out)) else $error("timer C complement wrong");
    a_zero_pair : assert property (
        fn_code_two == FN_ZERO && fn_code_three == FN_NONZERO && !hold_w
        |=> status_output_n[1] != status_output_n[2]) else $error("zero pair not complementary");
    a_idc_level : assert property (
        fn_code_three == FN_IDC0 && !hold_w
        |=> status_output_n[2] == ($past(sts.idc_value) > $past(sts.current_threshold_setting)))
        else $error("bus current level wrong");
    a_pwr_limit : assert property (
        fn_code_two == FN_PWR_LIM && !hold_w
        |=> status_output_n[1] == $past(sts.power_limit)) else $error("power limit wrong");
    a_ff1_true : assert property (
        fn_code_three == FN_FF1 && !hold_w
        |=> status_output_n[2] == $past(sts.ff1_q)) else $error("flip-flop one wrong");
    a_accel_state : assert property (
        fn_code_three == FN_ACCEL && !hold_w
        |=> status_output_n[2] == $past(sts.accelerating)) else $error("accelerating wrong");

endmodule

/* File: bench/dsos_partner.sv */
`timescale 1ns/1ps
// peripheral that watches the status lines and counts rising edges of output one
module dsos_partner
    import dsos_pkg::*;
#(
    parameter int MAX_CLK_HZ = 3000  // fastest pulse train this peripheral can follow
) (
    input  wire logic              clk_sys,
    input  wire logic [NUM_DO-1:0] status_output_n,
    output logic [31:0]            edge_cnt,
    output logic                   too_fast
);
    logic        prev_q;
    logic [31:0] gap_q;

    initial edge_cnt = 32'h0;
    initial too_fast = 1'b0;
    initial prev_q = 1'b0;
    initial gap_q = 32'h0;

    // rate kept below ceiling
    // flags two rising edges closer than the period this peripheral can follow
    always @(posedge clk_sys) begin
        if (status_output_n[0] && !prev_q) begin
            edge_cnt <= edge_cnt + 32'h1;
            gap_q    <= 32'h0;
            if (edge_cnt != 32'h0 && gap_q < 32'(CLK_HZ / MAX_CLK_HZ)) begin
                too_fast <= 1'b1;
            end
        end else begin
            gap_q <= gap_q + 32'h1;
        end
        prev_q <= status_output_n[0];
    end
endmodule

/* File: bench/tb_drive_status_output_selector.sv */
`timescale 1ns/1ps
module tb_drive_status_output_selector
    import dsos_pkg::*;
;
    logic              clk_sys;
    logic              rst;
    dsos_status_s      sts;
    dsos_code_t        fn_code_one;
    dsos_code_t        fn_code_two;
    dsos_code_t        fn_code_three;
    logic [NUM_DO-1:0] status_output_n;
    logic [31:0]       edge_cnt;
    logic              too_fast;
    logic [NUM_DO-1:0] exp_q;
    int                num_errors;
    int                check_count;
    int                cyc;
    int                e;
    integer            seed;

`define CHK(got, want) begin check_count++; if ((got) !== (want)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, want); end end

    dsos_top dut (.clk_sys(clk_sys), .rst(rst), .sts(sts), .fn_code_one(fn_code_one),
        .fn_code_two(fn_code_two), .fn_code_three(fn_code_three),
        .status_output_n(status_output_n));

    dsos_partner peer (.clk_sys(clk_sys), .status_output_n(status_output_n),
        .edge_cnt(edge_cnt), .too_fast(too_fast));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic results();
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard, the whole run needs about 24100 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end

    // reference condition for one code, from the current stimulus
    function automatic bit mdl(int c);
        int f, af, i, j, a, l, p, s, t;
        f = int'(sts.output_frequency_value);
        s = int'(sts.set_frequency);
        t = int'(sts.speed_tolerance_setting);
        af = (f < 0) ? -f : f;
        i = ((c % 10) / 2) % 3;
        j = c % 3;
        a = int'(sts.analog_input[i*AIN_W +: AIN_W]);
        l = int'(sts.ain_compare_level[i*AIN_W +: AIN_W]);
        p = int'(sts.analog_input[j*AIN_W +: AIN_W]) * 3000;
        if (c inside {[21:30]}) return int'(sts.auto_step) == c - 20;
        case (c)
            1: return !sts.running && !sts.dc_braking;
            4: return sts.alarm;
            5: return !sts.alarm;
            6: return sts.dc_braking;
            7: return sts.running;
            10: return sts.running && !sts.dc_braking && af - s <= t && s - af <= t;
            11: return !mdl(10);
            12: return f >= 0;
            13: return sts.irms_value > sts.current_threshold_setting;
            14: return sts.timer_a_out;
            15: return af < t;
            16: return !mdl(15);
            17: return sts.running && sts.stalling;
            20: return sts.timer_b_out;
            32: return sts.ff1_q;
            33: return !sts.ff1_q;
            34: return sts.ff2_q;
            35: return !sts.ff2_q;
            38: return 1'b1;
            40: return !sts.timer_a_out;
            41: return !sts.timer_b_out;
            42: return sts.timer_c_out;
            43, 93: return !sts.timer_c_out;
            50: return sts.idc_value > sts.current_threshold_setting;
            51, 52, 53: return int'(sts.idc_pct) * 20460 > p;
            54, 55, 56: return int'(sts.irms_pct) * 20460 > p;
            57: return sts.power_limit;
            70, 72, 74: return sts.running && a > l;
            71, 73, 75: return sts.running && a < l;
            78: return sts.overload_level > 16'h01F4;
            79: return !mdl(78);
            80, 82, 84: return a > l;
            81, 83, 85: return a < l;
            86: return sts.accelerating;
            87: return sts.decelerating;
            88: return sts.discharging;
            90: return sts.running && f >= 0;
            91: return sts.running && f < 0;
            92: return sts.timer_c_enable_input && sts.timer_c_out;
            default: return 1'b0;
        endcase
    endfunction

    // fresh status and codes; compare levels kept within 0.0 .. 1023.0
    task automatic rnd();
        int f, p;
        f = $random(seed) % 40;
        sts[$bits(sts)-1 -: 14] = 14'($random(seed));
        sts.output_frequency_value = 17'(f);
        sts.set_frequency = 16'(((f < 0) ? -f : f) + 5 + ($random(seed) % 6));
        sts.speed_tolerance_setting = 16'($random(seed) & 31);
        sts.auto_step = 4'(($random(seed) & 15) % 12);
        sts.irms_value = 16'($random(seed) & 255);
        sts.idc_value = 16'($random(seed) & 255);
        sts.current_threshold_setting = 16'($random(seed) & 255);
        sts.irms_pct = 16'($random(seed) & 2047);
        sts.idc_pct = 16'($random(seed) & 2047);
        sts.overload_level = 16'(480 + ($random(seed) & 63));
        for (int k = 0; k < 3; k++) begin
            sts.analog_input[k*AIN_W +: AIN_W] = 14'(($random(seed) & 1023) * 10);
            sts.ain_compare_level[k*AIN_W +: AIN_W] = 14'(($random(seed) & 1023) * 10);
        end
        // paired codes now and then, so the pair checks see traffic
        p = $random(seed) & 15;
        fn_code_one = 7'($random(seed));
        fn_code_two = (p == 0) ? 7'h0A : (p == 1) ? 7'h0F : 7'($random(seed));
        fn_code_three = (p == 0) ? 7'h0B : (p == 1) ? 7'h10 : 7'($random(seed));
    endtask

    initial begin
        seed = 32'h27c5231c;
        num_errors = 0;
        check_count = 0;
        cyc = 0;
        sts = '0;
        sts.output_frequency_value = 17'h01388;  // 50.00 Hz, x32 gives 1600 Hz
        // clock mode chosen while reset is applied
        fn_code_one = 7'h2C;
        fn_code_two = 7'h2C;
        fn_code_three = 7'h26;
        rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (10000) @(posedge clk_sys);
        #1 fn_code_one = 7'h26;  // ignored until the next reset
        repeat (10100) @(posedge clk_sys);
        #1;
        // half period 3125 cycles over 20000 running cycles
        `CHK((edge_cnt >= 32'h3 && edge_cnt <= 32'h4), 1'b1)
        `CHK(too_fast, 1'b0)
        `CHK(status_output_n[1], 1'b0)
        `CHK(status_output_n[2], 1'b1)
        // leave clock mode through a reset, then random codes and status
        fn_code_one = 7'h00;
        rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        e = 0;
        exp_q = 3'h0;
        rnd();
        for (int n = 0; n < 4000; n++) begin
            @(posedge clk_sys);
            #1 e++;
            `CHK(status_output_n, exp_q)
            rnd();
            rst = (n >= 1500 && n < 1502);
            if (rst && fn_code_one inside {[44:49]}) fn_code_one = 7'h00;
            if (rst) e = -1;
            exp_q = (e + 1 >= 101) ? {mdl(fn_code_three), mdl(fn_code_two), mdl(fn_code_one)}
                                   : 3'h0;
        end
        results();
    end
endmodule
